// File: rtl/taskfile_pkg.sv
package taskfile_pkg;
	// Word-indexed register map: byte address is four times the index
	localparam logic [2:0] IDX_DATA     = 3'h0;
	localparam logic [2:0] IDX_SUBCMD   = 3'h1;
	localparam logic [2:0] IDX_COUNT    = 3'h2;
	localparam logic [2:0] IDX_START    = 3'h3;
	localparam logic [2:0] IDX_TRK_LO   = 3'h4;
	localparam logic [2:0] IDX_TRK_HI   = 3'h5;
	localparam logic [2:0] IDX_UNIT     = 3'h6;
	localparam logic [2:0] IDX_OPCODE   = 3'h7;
	// Own registers above the task file
	localparam logic [3:0] IDX_CONFIG   = 4'h8;
	localparam logic [3:0] IDX_SEEKPOS  = 4'h9;
	localparam logic [3:0] IDX_EVENT    = 4'hA;
	localparam int         ADDR_W       = 6;

	// Opcodes
	localparam logic [3:0] OPN_RECAL    = 4'h1;
	localparam logic [3:0] OPN_SEEK     = 4'h7;
	localparam logic [7:0] OP_SENSE     = 8'h03;
	localparam logic [7:0] OP_SETFEAT   = 8'hEF;

	// Set-features subcommands
	localparam logic [7:0] SF_8BIT_ON   = 8'h01;
	localparam logic [7:0] SF_8BIT_OFF  = 8'h81;
	localparam logic [7:0] SF_WC_ON     = 8'h02;
	localparam logic [7:0] SF_WC_OFF    = 8'h82;
	localparam logic [7:0] SF_XFER      = 8'h03;
	localparam logic [7:0] SF_APM_ON    = 8'h05;
	localparam logic [7:0] SF_APM_OFF   = 8'h85;
	localparam logic [7:0] SF_PL1_ON    = 8'h0A;
	localparam logic [7:0] SF_PL1_OFF   = 8'h8A;
	localparam logic [7:0] SF_ECC_VEND  = 8'h44;
	localparam logic [7:0] SF_ECC_FOUR  = 8'hBB;
	localparam logic [7:0] SF_RLA_OFF   = 8'h55;
	localparam logic [7:0] SF_RLA_ON    = 8'hAA;
	localparam logic [7:0] SF_KEEP_ON   = 8'h66;
	localparam logic [7:0] SF_KEEP_OFF  = 8'hCC;
	localparam logic [7:0] SF_NOP_A     = 8'h69;
	localparam logic [7:0] SF_NOP_B     = 8'h96;
	localparam logic [7:0] SF_NOP_C     = 8'h97;
	localparam logic [7:0] SF_CURRENT   = 8'h9A;

	// Transfer mode type field (upper five bits of count byte)
	localparam logic [4:0] XT_PIO_DFLT  = 5'h00;
	localparam logic [4:0] XT_PIO_FLOW  = 5'h01;
	localparam logic [4:0] XT_MWDMA     = 5'h04;
	localparam logic [2:0] PIO_MAX      = 3'h6;
	localparam logic [2:0] MWDMA_MAX    = 3'h4;

	// Extended error codes
	localparam logic [7:0] EE_NONE      = 8'h00;
	localparam logic [7:0] EE_SELFTEST  = 8'h01;
	localparam logic [7:0] EE_WRFAIL    = 8'h03;
	localparam logic [7:0] EE_DIAG      = 8'h05;
	localparam logic [7:0] EE_MISC      = 8'h09;
	localparam logic [7:0] EE_UNCORR    = 8'h11;
	localparam logic [7:0] EE_CORR      = 8'h18;
	localparam logic [7:0] EE_XFER      = 8'h1F;
	localparam logic [7:0] EE_BADCMD    = 8'h20;
	localparam logic [7:0] EE_BADADDR   = 8'h21;
	localparam logic [7:0] EE_PL1       = 8'h22;
	localparam logic [7:0] EE_OVERFLOW  = 8'h2F;
	localparam logic [7:0] EE_VSUPPLY   = 8'h35;
	localparam logic [7:0] EE_VGEN      = 8'h36;

	// Status byte bits
	localparam int         ST_BUSY      = 7;
	localparam int         ST_READY     = 6;
	localparam int         ST_ERR       = 0;
	localparam logic [7:0] ERR_ABORT    = 8'h04;

	// Media event input bits (hardware event inputs; the event register reads the sense code)
	localparam int         EV_WRFAIL    = 0;
	localparam int         EV_UNCORR    = 1;
	localparam int         EV_CORR      = 2;
	localparam int         EV_XFER      = 3;
	localparam int         EV_VSUPPLY   = 4;
	localparam int         EV_VGEN      = 5;
	localparam int         EV_DIAGFAIL  = 6;
	localparam int         EV_DIAGOK    = 7;
	localparam int         EV_MISC      = 8;
	localparam int         EV_W         = 9;

	// Config register field positions
	localparam int         CF_8BIT      = 0;
	localparam int         CF_WC        = 1;
	localparam int         CF_APM       = 2;
	localparam int         CF_PL1       = 3;
	localparam int         CF_ECC4      = 4;
	localparam int         CF_RLA       = 5;
	localparam int         CF_KEEP      = 6;
	localparam int         CF_PIO_LSB   = 8;
	localparam int         CF_DMA_LSB   = 11;
	localparam int         CF_CUR_LSB   = 16;
	localparam int         CF_CAP       = 24;

	// Reset defaults
	localparam logic [2:0] PIO_DFLT     = 3'h0;
	localparam logic [2:0] DMA_DFLT     = 3'h0;
	localparam logic       RLA_DFLT     = 1'b1;
	localparam logic       PL1_DFLT     = 1'b1;
	localparam logic [7:0] CUR_DFLT     = 8'h00;
	localparam logic [27:0] CAPACITY    = 28'h0FFFFFF;
endpackage

// File: rtl/taskfile_cmd.sv
// Behaviour
// - Request sense 03h puts last extended error code in error register.
// - Code 00h for no error, 01h after a passed self test.
// - 20h bad command, 21h bad head or sector, 2Fh beyond capacity.
// - 35h or 36h for supply or generated voltage out of tolerance.
// - 03h write or erase failure, 11h uncorrectable, 18h corrected ECC.
// - Failed self test or diagnostic reported with 05h group codes.
// - 1Fh for transfer error or abort, 09h for miscellaneous errors.
// - 22h when a command is refused because power level 1 is off.
// - Opcodes 7Xh seek using head and track fields only.
// - Subcommand 01h selects 8-bit data, 81h restores 16-bit.
// - 02h enables write cache, 82h disables it after flushing.
// - Subcommand 03h sets transfer type and mode from count byte.
// - Exactly one PIO and one multiword DMA mode always selected.
// - 05h enables advanced power management, 85h disables it.
// - 0Ah permits power level 1 commands, 8Ah disallows them.
// - 44h vendor ECC bytes on long commands, BBh four bytes.
// - 55h disables read look-ahead, AAh enables it.
// - 66h keeps settings over soft reset, CCh reloads defaults.
// - 69h, 96h and 97h accepted with no effect.
// - 9Ah records host current-source capability.
module taskfile_cmd (
	input  wire logic                core_clk,
	input  wire logic                rstn,
	input  wire logic                clk_en,
	input  wire logic [5:0]          address,
	input  wire logic                read,
	input  wire logic                write,
	input  wire logic [31:0]         writedata,
	output logic      [31:0]         readdata,
	output logic                     waitrequest,
	input  wire logic                soft_reset,
	input  wire logic                flush_done,
	input  wire logic [8:0]          media_event,
	output logic                     flush_req,
	output logic                     wide_cycle_indication,
	output logic                     cmd_done
);
	typedef enum logic [1:0] {IDLE, EXEC, FLUSH} phase_e;

	typedef struct packed {
		phase_e      phase;
		logic [7:0]  subcmd;
		logic [7:0]  count;
		logic [7:0]  start;
		logic [7:0]  trk_lo;
		logic [7:0]  trk_hi;
		logic [7:0]  unit;
		logic [7:0]  opcode;
		logic [7:0]  status;
		logic [7:0]  err;
		logic [7:0]  sense;
		logic [27:0] seek_pos;
		logic        drive;
		logic        eight_bit;
		logic        wcache;
		logic        apm;
		logic        pl1;
		logic        ecc4;
		logic        rla;
		logic        keep;
		logic [2:0]  pio_mode;
		logic [2:0]  dma_mode;
		logic [7:0]  cur_cap;
		logic        done;
		logic        ack;
		logic [31:0] rdata;
	} state_s;

	state_s st_reg;
	state_s st_next;

	// Extended error code for a hardware event; lowest bit wins
	function automatic logic [7:0] event_code(input logic [8:0] ev);
		logic [7:0] c;
		c = taskfile_pkg::EE_NONE;
		if (ev[taskfile_pkg::EV_MISC])
			c = taskfile_pkg::EE_MISC;
		if (ev[taskfile_pkg::EV_DIAGOK])
			c = taskfile_pkg::EE_SELFTEST;
		if (ev[taskfile_pkg::EV_DIAGFAIL])
			c = taskfile_pkg::EE_DIAG;
		if (ev[taskfile_pkg::EV_VGEN])
			c = taskfile_pkg::EE_VGEN;
		if (ev[taskfile_pkg::EV_VSUPPLY])
			c = taskfile_pkg::EE_VSUPPLY;
		if (ev[taskfile_pkg::EV_XFER])
			c = taskfile_pkg::EE_XFER;
		if (ev[taskfile_pkg::EV_CORR])
			c = taskfile_pkg::EE_CORR;
		if (ev[taskfile_pkg::EV_UNCORR])
			c = taskfile_pkg::EE_UNCORR;
		if (ev[taskfile_pkg::EV_WRFAIL])
			c = taskfile_pkg::EE_WRFAIL;
		return c;
	endfunction

	// Power-on defaults of the feature settings
	function automatic state_s load_defaults(input state_s s);
		state_s r;
		r = s;
		r.eight_bit = 1'b0;
		r.wcache    = 1'b0;
		r.apm       = 1'b0;
		r.pl1       = taskfile_pkg::PL1_DFLT;
		r.ecc4      = 1'b0;
		r.rla       = taskfile_pkg::RLA_DFLT;
		r.keep      = 1'b0;
		r.pio_mode  = taskfile_pkg::PIO_DFLT;
		r.dma_mode  = taskfile_pkg::DMA_DFLT;
		r.cur_cap   = taskfile_pkg::CUR_DFLT;
		return r;
	endfunction

	logic [27:0] target;
	logic        bus_wr;
	logic        bus_rd;
	logic [3:0]  idx;
	logic        fail;
	logic [7:0]  fail_code;
	logic [4:0]  xtype;
	logic [2:0]  xmode;

	// Seek target from head and track fields only; the sector-number
	// register is a don't-care for seek, so the low byte stays zero
	assign target = {st_reg.unit[3:0], st_reg.trk_hi, st_reg.trk_lo,
		8'h00};
	assign idx    = address[5:2];
	assign bus_wr = write && !st_reg.ack;
	assign bus_rd = read && !st_reg.ack;
	assign xtype  = st_reg.count[7:3];
	assign xmode  = st_reg.count[2:0];

	// Next-state logic: bus slave, command decode, feature settings
	always_comb begin
		st_next      = st_reg;
		st_next.done = 1'b0;
		st_next.ack  = 1'b0;
		fail         = 1'b0;
		fail_code    = taskfile_pkg::EE_NONE;
		// Media events update the sense code in any phase; a command other than request sense overrides them in its decode cycle
		if (media_event != 9'h000)
			st_next.sense = event_code(media_event);
		if (soft_reset && !st_reg.keep)
			st_next = load_defaults(st_next);
		// One wait state per access gives registered read data
		if (bus_wr || bus_rd)
			st_next.ack = 1'b1;
		if (bus_rd) begin
			st_next.rdata = 32'h0000_0000;
			unique case (idx)
				{1'b0, taskfile_pkg::IDX_SUBCMD}:
					st_next.rdata[7:0] = st_reg.err;
				{1'b0, taskfile_pkg::IDX_COUNT}:
					st_next.rdata[7:0] = st_reg.count;
				{1'b0, taskfile_pkg::IDX_START}:
					st_next.rdata[7:0] = st_reg.start;
				{1'b0, taskfile_pkg::IDX_TRK_LO}:
					st_next.rdata[7:0] = st_reg.trk_lo;
				{1'b0, taskfile_pkg::IDX_TRK_HI}:
					st_next.rdata[7:0] = st_reg.trk_hi;
				{1'b0, taskfile_pkg::IDX_UNIT}:
					st_next.rdata[7:0] = st_reg.unit;
				{1'b0, taskfile_pkg::IDX_OPCODE}:
					st_next.rdata[7:0] = st_reg.status;
				taskfile_pkg::IDX_CONFIG: begin
					st_next.rdata[taskfile_pkg::CF_8BIT] = st_reg.eight_bit;
					st_next.rdata[taskfile_pkg::CF_WC]   = st_reg.wcache;
					st_next.rdata[taskfile_pkg::CF_APM]  = st_reg.apm;
					st_next.rdata[taskfile_pkg::CF_PL1]  = st_reg.pl1;
					st_next.rdata[taskfile_pkg::CF_ECC4] = st_reg.ecc4;
					st_next.rdata[taskfile_pkg::CF_RLA]  = st_reg.rla;
					st_next.rdata[taskfile_pkg::CF_KEEP] = st_reg.keep;
					st_next.rdata[taskfile_pkg::CF_PIO_LSB +: 3] =
						st_reg.pio_mode;
					st_next.rdata[taskfile_pkg::CF_DMA_LSB +: 3] =
						st_reg.dma_mode;
					st_next.rdata[taskfile_pkg::CF_CUR_LSB +: 8] =
						st_reg.cur_cap;
					st_next.rdata[taskfile_pkg::CF_CAP] = st_reg.drive;
				end
				taskfile_pkg::IDX_SEEKPOS:
					st_next.rdata[27:0] = st_reg.seek_pos;
				taskfile_pkg::IDX_EVENT:
					st_next.rdata[7:0] = st_reg.sense;
				default:
					st_next.rdata = 32'h0000_0000;
			endcase
		end
		// Task-file writes are ignored while a command runs
		if (bus_wr && st_reg.phase == IDLE) begin
			unique case (idx)
				{1'b0, taskfile_pkg::IDX_SUBCMD}:
					st_next.subcmd = writedata[7:0];
				{1'b0, taskfile_pkg::IDX_COUNT}:
					st_next.count = writedata[7:0];
				{1'b0, taskfile_pkg::IDX_START}:
					st_next.start = writedata[7:0];
				{1'b0, taskfile_pkg::IDX_TRK_LO}:
					st_next.trk_lo = writedata[7:0];
				{1'b0, taskfile_pkg::IDX_TRK_HI}:
					st_next.trk_hi = writedata[7:0];
				{1'b0, taskfile_pkg::IDX_UNIT}:
					st_next.unit = writedata[7:0];
				{1'b0, taskfile_pkg::IDX_OPCODE}: begin
					st_next.opcode = writedata[7:0];
					st_next.status[taskfile_pkg::ST_BUSY]  = 1'b1;
					st_next.status[taskfile_pkg::ST_READY] = 1'b0;
					st_next.phase = EXEC;
				end
				default: ;
			endcase
		end
		// Decode and execute the latched opcode
		if (st_reg.phase == EXEC) begin
			st_next.phase = IDLE;
			st_next.drive = st_reg.unit[4];
			if (st_reg.opcode[7:4] == taskfile_pkg::OPN_RECAL) begin
				st_next.seek_pos = 28'h0000000;
			end else if (st_reg.opcode[7:4] == taskfile_pkg::OPN_SEEK) begin
				if (target > taskfile_pkg::CAPACITY) begin
					fail      = 1'b1;
					fail_code = taskfile_pkg::EE_OVERFLOW;
				end else if (!st_reg.unit[7] || !st_reg.unit[5]) begin
					// Fixed-one bits of the unit byte cleared: bad head field
					fail      = 1'b1;
					fail_code = taskfile_pkg::EE_BADADDR;
				end else begin
					st_next.seek_pos = target;
				end
			end else if (st_reg.opcode == taskfile_pkg::OP_SENSE) begin
				st_next.err = st_reg.sense;
			end else if (st_reg.opcode == taskfile_pkg::OP_SETFEAT) begin
				unique case (st_reg.subcmd)
					taskfile_pkg::SF_8BIT_ON:  st_next.eight_bit = 1'b1;
					taskfile_pkg::SF_8BIT_OFF: st_next.eight_bit = 1'b0;
					taskfile_pkg::SF_WC_ON:    st_next.wcache = 1'b1;
					taskfile_pkg::SF_WC_OFF: begin
						st_next.wcache = 1'b0;
						if (st_reg.wcache)
							st_next.phase = FLUSH;
					end
					taskfile_pkg::SF_XFER: begin
						// Only the changed class moves; the other stays selected
						if ((xtype == taskfile_pkg::XT_PIO_DFLT ||
							xtype == taskfile_pkg::XT_PIO_FLOW) &&
							xmode <= taskfile_pkg::PIO_MAX)
							st_next.pio_mode = xmode;
						else if (xtype == taskfile_pkg::XT_MWDMA &&
							xmode <= taskfile_pkg::MWDMA_MAX)
							st_next.dma_mode = xmode;
						else begin
							fail      = 1'b1;
							fail_code = taskfile_pkg::EE_XFER;
						end
					end
					taskfile_pkg::SF_APM_ON:   st_next.apm = 1'b1;
					taskfile_pkg::SF_APM_OFF:  st_next.apm = 1'b0;
					taskfile_pkg::SF_PL1_ON:   st_next.pl1 = 1'b1;
					taskfile_pkg::SF_PL1_OFF:  st_next.pl1 = 1'b0;
					taskfile_pkg::SF_ECC_VEND: st_next.ecc4 = 1'b0;
					taskfile_pkg::SF_ECC_FOUR: st_next.ecc4 = 1'b1;
					taskfile_pkg::SF_RLA_OFF:  st_next.rla = 1'b0;
					taskfile_pkg::SF_RLA_ON:   st_next.rla = 1'b1;
					taskfile_pkg::SF_KEEP_ON:  st_next.keep = 1'b1;
					taskfile_pkg::SF_KEEP_OFF: st_next.keep = 1'b0;
					taskfile_pkg::SF_NOP_A,
					taskfile_pkg::SF_NOP_B,
					taskfile_pkg::SF_NOP_C: ;
					taskfile_pkg::SF_CURRENT: begin
						// Current-source setting counts as a level 1 command
						if (st_reg.pl1)
							st_next.cur_cap = st_reg.count;
						else begin
							fail      = 1'b1;
							fail_code = taskfile_pkg::EE_PL1;
						end
					end
					default: begin
						fail      = 1'b1;
						fail_code = taskfile_pkg::EE_BADCMD;
					end
				endcase
			end else begin
				fail      = 1'b1;
				fail_code = taskfile_pkg::EE_BADCMD;
			end
			if (st_next.phase == IDLE) begin
				st_next.done = 1'b1;
				st_next.status[taskfile_pkg::ST_BUSY]  = 1'b0;
				st_next.status[taskfile_pkg::ST_READY] = 1'b1;
				st_next.status[taskfile_pkg::ST_ERR]   = fail;
				st_next.err = fail ? taskfile_pkg::ERR_ABORT : st_next.err;
			end
			// Sense reports this command's outcome next time
			if (st_reg.opcode != taskfile_pkg::OP_SENSE)
				st_next.sense = fail ? fail_code : taskfile_pkg::EE_NONE;
		end
		// Completion waits for the flush handshake
		if (st_reg.phase == FLUSH && flush_done) begin
			st_next.phase = IDLE;
			st_next.done  = 1'b1;
			st_next.status[taskfile_pkg::ST_BUSY]  = 1'b0;
			st_next.status[taskfile_pkg::ST_READY] = 1'b1;
			st_next.status[taskfile_pkg::ST_ERR]   = 1'b0;
		end
	end

	// Single state register; clock enable freezes everything
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg        <= '0;
			st_reg.phase  <= IDLE;
			st_reg.pl1    <= taskfile_pkg::PL1_DFLT;
			st_reg.rla    <= taskfile_pkg::RLA_DFLT;
			st_reg.status <= 8'h40;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	assign readdata    = st_reg.rdata;
	// Answer only in an enabled cycle: ack then clears at the very edge
	// where the master completes, so a frozen core never leaves a stale
	// acknowledge that would end the next request before it is taken
	assign waitrequest = (read || write) && !(st_reg.ack && clk_en);
	assign flush_req   = st_reg.phase == FLUSH;
	assign cmd_done    = st_reg.done;
	// 8-bit mode suppresses the wide-cycle indication
	assign wide_cycle_indication = !st_reg.eight_bit;

	a_sense_copy: assert property (@(posedge core_clk) disable iff (!rstn)
		clk_en && st_reg.phase == EXEC &&
		st_reg.opcode == taskfile_pkg::OP_SENSE |=>
		st_reg.err == $past(st_reg.sense))
		else $error("sense code not copied to error register");

	a_bad_cmd: assert property (@(posedge core_clk) disable iff (!rstn)
		clk_en && st_reg.phase == EXEC && st_reg.opcode == 8'h00 |=>
		st_reg.sense == taskfile_pkg::EE_BADCMD && st_reg.status[0])
		else $error("unknown opcode not reported");

	a_eight_bit: assert property (@(posedge core_clk) disable iff (!rstn)
		clk_en && st_reg.phase == EXEC && st_reg.opcode == 8'hEF &&
		st_reg.subcmd == taskfile_pkg::SF_8BIT_ON |=>
		!wide_cycle_indication)
		else $error("8-bit mode left wide cycles on");

	a_flush_wait: assert property (@(posedge core_clk) disable iff (!rstn)
		flush_req && !flush_done |=> !cmd_done)
		else $error("completion before flush");

	a_pio_range: assert property (@(posedge core_clk) disable iff (!rstn)
		st_reg.pio_mode <= taskfile_pkg::PIO_MAX &&
		st_reg.dma_mode <= taskfile_pkg::MWDMA_MAX)
		else $error("transfer mode out of range");

	a_seek_pos: assert property (@(posedge core_clk) disable iff (!rstn)
		clk_en && st_reg.phase == EXEC && st_reg.opcode[7:4] == 4'h7 &&
		target <= taskfile_pkg::CAPACITY &&
		st_reg.unit[7] && st_reg.unit[5] |=>
		st_reg.seek_pos == $past(target))
		else $error("seek target not taken");

	a_recal_done: assert property (@(posedge core_clk) disable iff (!rstn)
		clk_en && st_reg.phase == EXEC && st_reg.opcode[7:4] == 4'h1 |=>
		cmd_done && st_reg.seek_pos == 28'h0000000 && !st_reg.status[0])
		else $error("recalibrate did not complete cleanly");

	a_pl1_off: assert property (@(posedge core_clk) disable iff (!rstn)
		clk_en && st_reg.phase == EXEC && st_reg.opcode == 8'hEF &&
		st_reg.subcmd == taskfile_pkg::SF_PL1_OFF |=> !st_reg.pl1)
		else $error("power level 1 still permitted");
endmodule

// File: tb/flush_cache_model.sv
module flush_cache_model (
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic       flush_req,
	input  wire logic [3:0] delay,
	output logic            flush_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_reg;

	// Cache answers after a chosen delay; done drops once request goes
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= 4'h0;
			flush_done <= 1'b0;
		end else if (flush_req !== 1'b1) begin
			cnt_reg <= 4'h0;
			flush_done <= 1'b0;
		end else if (cnt_reg >= delay) begin
			flush_done <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 4'h1;
		end
	end
endmodule

// File: tb/ata_task_file_command_subset_tb.sv
module ata_task_file_command_subset_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        clk_en = 1'b1;
	logic [5:0]  address = 6'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h00000000;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        soft_reset = 1'b0;
	logic        flush_done;
	logic [8:0]  media_event = 9'h000;
	logic        flush_req;
	logic        wide_cycle_indication;
	logic        cmd_done;
	logic [3:0]  flush_delay = 4'h1;
	logic        flush_seen = 1'b0;
	logic [31:0] cfg = 32'h00000028;
	logic [31:0] rd;
	// Error register keeps its value across a successful command other than request sense
	logic [7:0]  err_exp = 8'h00;
	logic [31:0] seed = 32'h00000033;
	int          err_total = 0;
	int          samples_checked = 0;

	always #5 core_clk = ~core_clk;

	taskfile_cmd taskfile_cmd_inst (.core_clk(core_clk), .rstn(rstn),
		.clk_en(clk_en), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .soft_reset(soft_reset),
		.flush_done(flush_done), .media_event(media_event),
		.flush_req(flush_req), .cmd_done(cmd_done),
		.wide_cycle_indication(wide_cycle_indication));
	flush_cache_model flush_cache_model_inst (.core_clk(core_clk),
		.rstn(rstn), .flush_req(flush_req), .delay(flush_delay),
		.flush_done(flush_done));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Expected code and settings after one set-features subcommand
	function automatic logic [7:0] sf_exp(input logic [7:0] s,
		input logic [7:0] c, inout logic [31:0] f);
		sf_exp = 8'h00;
		case (s)
		8'h01: f[0] = 1'b1;
		8'h81: f[0] = 1'b0;
		8'h02: f[1] = 1'b1;
		8'h82: f[1] = 1'b0;
		8'h05: f[2] = 1'b1;
		8'h85: f[2] = 1'b0;
		8'h0A: f[3] = 1'b1;
		8'h8A: f[3] = 1'b0;
		8'h44: f[4] = 1'b0;
		8'hBB: f[4] = 1'b1;
		8'h55: f[5] = 1'b0;
		8'hAA: f[5] = 1'b1;
		8'h66: f[6] = 1'b1;
		8'hCC: f[6] = 1'b0;
		8'h69, 8'h96, 8'h97: ;
		8'h9A: begin
			if (f[3])
				f[23:16] = c;
			else
				sf_exp = 8'h22;
		end
		8'h03: begin
			if (c[7:4] == 4'h0 && c[2:0] <= 3'h6)
				f[10:8] = c[2:0];
			else if (c[7:3] == 5'h04 && c[2:0] <= 3'h4)
				f[13:11] = c[2:0];
			else
				sf_exp = 8'h1F;
		end
		default: sf_exp = 8'h20;
		endcase
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Avalon access: held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [3:0] i,
		input logic [7:0] d, output logic [31:0] q);
		int  n;
		logic wt;
		n = 0;
		@(posedge core_clk);
		address <= {i, 2'b00};
		writedata <= {24'h000000, d};
		write <= w;
		read <= ~w;
		// Waitrequest and read data are taken at the same rising edge
		do begin
			@(posedge core_clk);
			wt = waitrequest;
			q = readdata;
			n++;
		end while (wt !== 1'b0 && n < 64);
		chk("bus_ack", 32'h00000000, {31'h0, wt});
		write <= 1'b0;
		read <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] i, input logic [7:0] d);
		bus(1'b1, i, d, rd);
	endtask

	task automatic rdc(input logic [3:0] i, input logic [31:0] e,
		input string nm);
		bus(1'b0, i, 8'h00, rd);
		chk(nm, e, rd);
	endtask

	task automatic wait_done();
		int n;
		n = 0;
		// Done rises no earlier than the edge that completes the opcode write
		do begin
			@(posedge core_clk);
			n++;
		end while (cmd_done !== 1'b1 && n < 300);
		chk("cmd_done", 32'h00000001, {31'h0, cmd_done});
	endtask

	task automatic cmd(input logic [7:0] op);
		wr(4'h7, op);
		wait_done();
	endtask

	// Status, error, sensed code and settings after a command
	task automatic result(input logic [7:0] e);
		rdc(4'h7, (e == 8'h00) ? 32'h40 : 32'h41, "status");
		rdc(4'h1, (e == 8'h00) ? {24'h0, err_exp} : 32'h04, "error");
		cmd(8'h03);
		rdc(4'h1, {24'h0, e}, "sense");
		err_exp = e;
		bus(1'b0, 4'h8, 8'h00, rd);
		chk("config", cfg, rd & 32'h00FFFFFF);
		chk("wide", {31'h0, ~cfg[0]}, {31'h0, wide_cycle_indication});
	endtask

	task automatic setf(input logic [7:0] s, input logic [7:0] c);
		logic [7:0] e;
		logic       w;
		w = cfg[1];
		e = sf_exp(s, c, cfg);
		flush_seen = 1'b0;
		wr(4'h1, s);
		wr(4'h2, c);
		cmd(8'hEF);
		chk("flush", {31'h0, w & ~cfg[1]}, {31'h0, flush_seen});
		result(e);
	endtask

	task automatic seek(input logic [7:0] u, input logic [7:0] s);
		logic [31:0] t;
		logic [27:0] a;
		logic [7:0]  e;
		t = rnd();
		wr(4'h1, t[7:0]);
		wr(4'h2, t[31:24]);
		wr(4'h3, s);
		wr(4'h4, t[15:8]);
		wr(4'h5, t[23:16]);
		wr(4'h6, u);
		a = {u[3:0], t[23:16], t[15:8], 8'h00};
		e = (a > 28'h0FFFFFF) ? 8'h2F :
			(!u[7] || !u[5]) ? 8'h21 : 8'h00;
		cmd({4'h7, t[27:24]});
		result(e);
		if (e == 8'h00)
			rdc(4'h9, {4'h0, a}, "seekpos");
	endtask

	task automatic soft_pulse();
		soft_reset <= 1'b1;
		repeat (6) @(posedge core_clk);
		soft_reset <= 1'b0;
		bus(1'b0, 4'h8, 8'h00, rd);
		chk("config_soft", cfg, rd & 32'h00FFFFFF);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Random stalls of the core; flush must precede completion
	always @(posedge core_clk) begin
		clk_en <= (rnd() & 32'h00000007) != 32'h00000000;
		if (flush_req === 1'b1)
			flush_seen <= 1'b1;
		if (cmd_done === 1'b1)
			chk("flush_at_done", 32'h0, {31'h0, flush_req});
	end

	initial begin
		#500000;
		err_total++;
		test_done();
	end

	initial begin
		logic [15:0] tb_sf[24];
		logic [7:0]  me[9];
		logic [7:0]  c;
		tb_sf = '{16'h0100, 16'h8100, 16'h0200, 16'h8200, 16'h0500,
			16'h8500, 16'h0A00, 16'h8A00, 16'hBB00, 16'h4400, 16'h5500,
			16'hAA00, 16'h6600, 16'hCC00, 16'h6900, 16'h9600, 16'h9700,
			16'h9A00, 16'h0306, 16'h030B, 16'h030F, 16'h0324, 16'h0325,
			16'h7700};
		me = '{8'h03, 8'h11, 8'h18, 8'h1F, 8'h35, 8'h36, 8'h05, 8'h01,
			8'h09};
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		rdc(4'h7, 32'h00000040, "status_rst");
		rdc(4'h8, cfg, "config_rst");
		chk("wide_rst", 32'h1, {31'h0, wide_cycle_indication});
		wr(4'hC, 8'hFF);
		rdc(4'hC, 32'h00000000, "unmapped");
		for (int i = 2; i < 7; i++) begin
			c = 8'(rnd());
			wr(i[3:0], c);
			rdc(i[3:0], {24'h0, c}, "taskfile_rw");
		end
		$display("test registers done");
		for (int i = 0; i < 24; i++) begin
			c = (tb_sf[i][15:8] == 8'h9A) ? 8'(rnd()) : tb_sf[i][7:0];
			setf(tb_sf[i][15:8], c);
		end
		setf(8'h0A, 8'h00);
		c = 8'(rnd());
		setf(8'h9A, c);
		$display("test set_features done");
		setf(8'h02, 8'h00);
		flush_delay = 4'hC;
		wr(4'h1, 8'h82);
		wr(4'h7, 8'hEF);
		wr(4'h2, 8'h5A);
		c = sf_exp(8'h82, 8'h00, cfg);
		wait_done();
		rdc(4'h2, 32'h00000000, "busy_refused");
		$display("test slow_flush done");
		for (int i = 0; i < 8; i++) begin
			c = 8'(rnd());
			seek({4'hE, (i < 4) ? 4'h0 : c[7:4]}, c);
		end
		seek(8'h20, 8'h00);
		seek(8'hA0, 8'h05);
		$display("test seek done");
		c = 8'(rnd());
		wr(4'h2, c);
		cmd({4'h1, c[3:0]});
		result(8'h00);
		cmd(8'h00);
		result(8'h20);
		$display("test recal done");
		for (int i = 0; i < 10; i++) begin
			media_event <= (i < 9) ? (9'h001 << i) : 9'h024;
			repeat (4) @(posedge core_clk);
			media_event <= 9'h000;
			cmd(8'h03);
			rdc(4'h1, {24'h0, me[(i < 9) ? i : 2]}, "media");
			err_exp = me[(i < 9) ? i : 2];
		end
		$display("test media done");
		setf(8'h55, 8'h00);
		cfg = 32'h00000028;
		soft_pulse();
		setf(8'h66, 8'h00);
		setf(8'h55, 8'h00);
		soft_pulse();
		$display("test soft_reset done");
		test_done();
	end
endmodule
